/* File: src/dtm_timer.sv */
// Dual 16-bit timer unit with reference counter and Wishbone registers
`default_nettype none
// Operation
// - 16-bit reference counter advances once every 192 clocks, shared.
// - Two independent 16-bit timers, each match, event or capture mode.
// - Match mode drives a pulse on that timer's own output pin.
// - Pulse period is FFFF minus reload; high part is reference value.
// - Rollover or match sets the timer's status bit and interrupt.
// - Event mode counts input events, flags when programmed count reached.
// - Event is rising, falling, either edge, or level, by software.
// - Capture mode stores reference count on each event, flags, interrupts.
module dtm_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer pins
  input wire logic first_timer_pin_i,
  input wire logic second_timer_pin_i,
  output logic first_timer_pin_o,
  output logic second_timer_pin_o,
  // Interrupts
  output logic [1:0] tmr_irq_o,
  output logic irq_o
);
  logic [7:0] pre_cnt_reg;
  logic tick;
  logic [15:0] ref_cnt_reg;
  logic req;
  logic wr;
  logic rd_status;
  logic [31:0] rd_mux;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] mask_reg;
  logic [7:0] evt;
  logic [1:0] pin_raw;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] lvl_reg;
  logic [1:0] pin_out;
  logic [3:0] ctrl_reg [2];
  logic [15:0] reload_reg [2];
  logic [15:0] mref_reg [2];
  logic [15:0] count [2];
  logic [15:0] capture [2];

  function automatic logic tmr_hit(input logic [7:0] adr,
                                   input int idx,
                                   input logic [7:0] off);
    return adr == 8'(dtm_pkg::TMR_BASE + idx * dtm_pkg::TMR_STRIDE) + off;
  endfunction

  function automatic logic [15:0] sel16(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) res[7:0] = dat[7:0];
    if (sel[1]) res[15:8] = dat[15:8];
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Reference timebase
  assign tick = pre_cnt_reg == dtm_pkg::PRESCALE_LAST;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) pre_cnt_reg <= 8'h00;
    else if (tick) pre_cnt_reg <= 8'h00;
    else pre_cnt_reg <= pre_cnt_reg + 8'h01;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) ref_cnt_reg <= dtm_pkg::REG16_RST;
    else if (tick) ref_cnt_reg <= ref_cnt_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pin_raw = {second_timer_pin_i, first_timer_pin_i};

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) lvl_reg <= 2'h0;
    else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) lvl_reg[i] <= sync3_reg[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd_status = req & ~wb_we_i & wb_adr_i == dtm_pkg::ADR_STATUS;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= req;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == dtm_pkg::ADR_REFCNT) rd_mux[15:0] = ref_cnt_reg;
    if (wb_adr_i == dtm_pkg::ADR_STATUS) rd_mux[7:0] = status_reg;
    if (wb_adr_i == dtm_pkg::ADR_MASK) rd_mux[7:0] = mask_reg;
    for (int i = 0; i < 2; i++) begin
      if (tmr_hit(wb_adr_i, i, dtm_pkg::OFF_CTRL)) begin
        rd_mux[3:0] = ctrl_reg[i];
      end
      if (tmr_hit(wb_adr_i, i, dtm_pkg::OFF_RELOAD)) begin
        rd_mux[15:0] = reload_reg[i];
      end
      if (tmr_hit(wb_adr_i, i, dtm_pkg::OFF_REF)) begin
        rd_mux[15:0] = ctrl_reg[i][1:0] == dtm_pkg::DTM_CAPT ?
                       capture[i] : mref_reg[i];
      end
      if (tmr_hit(wb_adr_i, i, dtm_pkg::OFF_COUNT)) begin
        rd_mux[15:0] = count[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i) wb_dat_o <= rd_mux;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) mask_reg <= dtm_pkg::ST_RST;
    else if (wr && wb_adr_i == dtm_pkg::ADR_MASK && wb_sel_i[0]) begin
      mask_reg <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Timer channels
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ctrl_reg[g] <= dtm_pkg::CTRL_RST;
        reload_reg[g] <= dtm_pkg::REG16_RST;
        mref_reg[g] <= dtm_pkg::REG16_RST;
      end else if (wr) begin
        if (tmr_hit(wb_adr_i, g, dtm_pkg::OFF_CTRL) && wb_sel_i[0]) begin
          ctrl_reg[g] <= wb_dat_i[3:0];
        end
        if (tmr_hit(wb_adr_i, g, dtm_pkg::OFF_RELOAD)) begin
          reload_reg[g] <= sel16(reload_reg[g], wb_dat_i, wb_sel_i);
        end
        if (tmr_hit(wb_adr_i, g, dtm_pkg::OFF_REF)) begin
          mref_reg[g] <= sel16(mref_reg[g], wb_dat_i, wb_sel_i);
        end
      end
    end

    dtm_chan u_chan (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick),
      .ref_cnt_i(ref_cnt_reg),
      .mode_i(ctrl_reg[g][dtm_pkg::CTRL_MODE_LSB +: 2]),
      .edge_i(ctrl_reg[g][dtm_pkg::CTRL_EDGE_LSB +: 2]),
      .reload_i(reload_reg[g]),
      .match_ref_i(mref_reg[g]),
      .lvl_i(lvl_reg[g]),
      .count_o(count[g]),
      .capture_o(capture[g]),
      .pin_o(pin_out[g]),
      .evt_o(evt[g*dtm_pkg::ST_W +: dtm_pkg::ST_W])
    );

    assign tmr_irq_o[g] =
      |(status_reg[g*dtm_pkg::ST_W +: dtm_pkg::ST_W] &
        mask_reg[g*dtm_pkg::ST_W +: dtm_pkg::ST_W]);
  end

  assign first_timer_pin_o = pin_out[0];
  assign second_timer_pin_o = pin_out[1];

  ////////////////////////////////////////////////////////////////////
  // Status and interrupt
  assign status_next = (rd_status ? 8'h00 : status_reg) | evt;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) status_reg <= dtm_pkg::ST_RST;
    else status_reg <= status_next;
  end

  assign irq_o = |tmr_irq_o;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_tick_period: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    tick |-> ##192 tick)
    else $error("reference tick period is not 192 clocks");
  chk_tick_gap: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    tick |=> (!tick) [*8])
    else $error("reference ticks too close");
  chk_ref_step: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    tick |=> ref_cnt_reg == $past(ref_cnt_reg) + 16'h0001)
    else $error("reference count did not advance");
  chk_ref_hold: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    !tick |=> $stable(ref_cnt_reg))
    else $error("reference count moved without tick");
  chk_evt_status: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    evt[dtm_pkg::ST_ROLL] || evt[dtm_pkg::ST_MATCH]
    |=> status_reg[dtm_pkg::ST_ROLL] || status_reg[dtm_pkg::ST_MATCH])
    else $error("timer event did not set status");
  chk_status_sticky: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    status_reg[0] && !rd_status |=> status_reg[0])
    else $error("status bit lost without a status read");
  chk_irq_follow: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    evt[dtm_pkg::ST_CAPT] && mask_reg[dtm_pkg::ST_CAPT]
    |=> tmr_irq_o[0] && irq_o)
    else $error("unmasked event raised no interrupt");
  chk_pin_mode: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 $past(ctrl_reg[1][1:0]) != dtm_pkg::DTM_MATCH
    |-> !second_timer_pin_o)
    else $error("pin driven outside match mode");
  chk_ack_pulse: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Bus, status and pin checks
  chk_write_at_ack: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    $changed(mask_reg) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("mask changed outside an acknowledged write");
  chk_mask_write: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    wr && wb_adr_i == dtm_pkg::ADR_MASK && wb_sel_i[0]
    |=> mask_reg == $past(wb_dat_i[7:0]))
    else $error("mask write did not land");
  chk_status_clear: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    rd_status |=> status_reg == $past(evt))
    else $error("status read did not clear the bits");
  chk_status_read: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    rd_status |=> wb_dat_o[7:0] == $past(status_reg))
    else $error("status read returned a wrong value");
  chk_sync_agree: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    $changed(lvl_reg[0]) |-> lvl_reg[0] == $past(sync2_reg[0])
    && lvl_reg[0] == $past(sync3_reg[0]))
    else $error("pin level taken before two stages agreed");
  chk_pin_mode0: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 $past(ctrl_reg[0][1:0]) != dtm_pkg::DTM_MATCH
    |-> !first_timer_pin_o)
    else $error("first pin driven outside match mode");
  chk_roll_pin: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    evt[dtm_pkg::ST_ROLL] && $past(mref_reg[0]) != dtm_pkg::REG16_RST
    |-> first_timer_pin_o)
    else $error("rollover did not start the high part");
  chk_ref_read: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req && !wb_we_i && tmr_hit(wb_adr_i, 0, dtm_pkg::OFF_REF)
    && ctrl_reg[0][1:0] == dtm_pkg::DTM_CAPT
    |=> wb_dat_o[15:0] == $past(capture[0]))
    else $error("capture value not returned on read");
  cov_toggle: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    $rose(first_timer_pin_o) ##[1:1000] $fell(first_timer_pin_o));
  cov_count_done: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i) evt[dtm_pkg::ST_COUNT]);
  cov_irq_clear: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    irq_o ##1 rd_status ##1 !irq_o);
  cov_both_high: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    first_timer_pin_o && second_timer_pin_o);
endmodule : dtm_timer
`default_nettype wire

/* File: src/dtm_pkg.sv */
// Shared constants and types of the dual match/capture timer
`default_nettype none
package dtm_pkg;
  // Reference timebase
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned PRESCALE_CYC = 192;
  localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE_CYC - 1);
  localparam logic [15:0] WRAP_AT = 16'hfffe;
  // Byte addresses
  localparam logic [7:0] ADR_REFCNT = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam int unsigned TMR_BASE = 16;
  localparam int unsigned TMR_STRIDE = 16;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RELOAD = 8'h04;
  localparam logic [7:0] OFF_REF = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  // Control fields
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_EDGE_LSB = 2;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] REG16_RST = 16'h0000;
  // Status bits per timer
  localparam int unsigned ST_W = 4;
  localparam int unsigned ST_ROLL = 0;
  localparam int unsigned ST_MATCH = 1;
  localparam int unsigned ST_COUNT = 2;
  localparam int unsigned ST_CAPT = 3;
  localparam logic [7:0] ST_RST = 8'h00;
  typedef enum logic [1:0] {
    DTM_OFF = 2'h0, DTM_MATCH = 2'h1, DTM_EVENT = 2'h3, DTM_CAPT = 2'h2
  } dtm_mode_t;
  typedef enum logic [1:0] {
    DTM_RISE = 2'h0, DTM_FALL = 2'h1, DTM_BOTH = 2'h2, DTM_LEVEL = 2'h3
  } dtm_edge_t;
endpackage : dtm_pkg
`default_nettype wire

/* File: src/dtm_chan.sv */
// One programmable timer channel: match, event count or capture
`default_nettype none
module dtm_chan (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Timebase
  input wire logic tick_i,
  input wire logic [15:0] ref_cnt_i,
  // Setup
  input wire logic [1:0] mode_i,
  input wire logic [1:0] edge_i,
  input wire logic [15:0] reload_i,
  input wire logic [15:0] match_ref_i,
  // Filtered pin level
  input wire logic lvl_i,
  // Results
  output logic [15:0] count_o,
  output logic [15:0] capture_o,
  output logic pin_o,
  output logic [3:0] evt_o
);
  logic lvl_prev_reg;
  logic [1:0] mode_prev_reg;
  logic ev;
  logic wrap;
  logic hit;
  logic done;
  logic [15:0] cnt_inc;

  ////////////////////////////////////////////////////////////////////
  // Event qualification
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) lvl_prev_reg <= 1'b0;
    else lvl_prev_reg <= lvl_i;
  end

  always_comb begin
    case (dtm_pkg::dtm_edge_t'(edge_i))
      dtm_pkg::DTM_RISE: ev = lvl_i & ~lvl_prev_reg;
      dtm_pkg::DTM_FALL: ev = ~lvl_i & lvl_prev_reg;
      dtm_pkg::DTM_BOTH: ev = lvl_i ^ lvl_prev_reg;
      default: ev = lvl_i & tick_i;
    endcase
  end

  assign cnt_inc = count_o + 16'h0001;
  assign wrap = tick_i && count_o == dtm_pkg::WRAP_AT;
  assign hit = tick_i && (cnt_inc - reload_i) == match_ref_i;
  assign done = ev && cnt_inc == match_ref_i;

  ////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= 16'h0000;
      mode_prev_reg <= 2'h0;
    end else begin
      mode_prev_reg <= mode_i;
      if (mode_i != mode_prev_reg) begin
        count_o <= (mode_i == dtm_pkg::DTM_MATCH) ? reload_i : 16'h0000;
      end else begin
        case (dtm_pkg::dtm_mode_t'(mode_i))
          dtm_pkg::DTM_MATCH: begin
            if (wrap) count_o <= reload_i;
            else if (tick_i) count_o <= cnt_inc;
          end
          dtm_pkg::DTM_EVENT: begin
            if (done) count_o <= 16'h0000;
            else if (ev) count_o <= cnt_inc;
          end
          default: count_o <= count_o;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pulse pin, capture and events
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) pin_o <= 1'b0;
    else if (mode_i != dtm_pkg::DTM_MATCH) pin_o <= 1'b0;
    else if (wrap) pin_o <= match_ref_i != 16'h0000;
    else if (hit) pin_o <= ~pin_o;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) capture_o <= 16'h0000;
    else if (mode_i == dtm_pkg::DTM_CAPT && ev) capture_o <= ref_cnt_i;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) evt_o <= 4'h0;
    else begin
      evt_o[dtm_pkg::ST_ROLL] <= mode_i == dtm_pkg::DTM_MATCH && wrap;
      evt_o[dtm_pkg::ST_MATCH] <= mode_i == dtm_pkg::DTM_MATCH && hit;
      evt_o[dtm_pkg::ST_COUNT] <= mode_i == dtm_pkg::DTM_EVENT && done;
      evt_o[dtm_pkg::ST_CAPT] <= mode_i == dtm_pkg::DTM_CAPT && ev;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_wrap_reload: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    mode_i == dtm_pkg::DTM_MATCH && $stable(mode_i) && wrap
    |=> count_o == $past(reload_i))
    else $error("match count did not wrap to reload");
  chk_capture_value: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    evt_o[dtm_pkg::ST_CAPT] |-> capture_o == $past(ref_cnt_i))
    else $error("capture value differs from reference count");
  chk_count_done: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    evt_o[dtm_pkg::ST_COUNT] |-> count_o == 16'h0000
    && $past(count_o) + 16'h0001 == $past(match_ref_i))
    else $error("event target flag without target reached");
  chk_rise_only: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    ##1 evt_o[dtm_pkg::ST_CAPT] && $past(edge_i) == dtm_pkg::DTM_RISE
    |-> $past(lvl_i) && !$past(lvl_i, 2))
    else $error("rise event without rising level");
  chk_pin_toggle: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    evt_o[dtm_pkg::ST_MATCH] && !evt_o[dtm_pkg::ST_ROLL]
    && $past(mode_i) == dtm_pkg::DTM_MATCH |-> pin_o != $past(pin_o))
    else $error("match did not toggle the pin");
  cov_capture: cover property (
    @(posedge core_clk_i) disable iff (!nrst_i) evt_o[dtm_pkg::ST_CAPT]);
endmodule : dtm_chan
`default_nettype wire

/* File: verif/dtm_pin_model.sv */
// Far-side pin model: drives the two timer event inputs
`default_nettype none
module dtm_pin_model (
  // Clock
  input wire logic core_clk_i,
  // Event pins
  output logic first_pin_o,
  output logic second_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    first_pin_o = 1'b0;
    second_pin_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Set one pin just after an edge, then hold it
  task automatic drive(input int which, input logic lvl, input int hold);
    @(posedge core_clk_i);
    if (which == 0) first_pin_o <= lvl;
    else second_pin_o <= lvl;
    repeat (hold) @(posedge core_clk_i);
  endtask
  // Whole pulses, high then low
  task automatic pulses(input int which, input int n, input int gap);
    repeat (n) begin
      drive(which, 1'b1, gap);
      drive(which, 1'b0, gap);
    end
  endtask
endmodule // dtm_pin_model
`default_nettype wire

/* File: verif/test_dtm_timer.sv */
// Self-checking bench of the dual timer unit
`default_nettype none
module test_dtm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, nrst_i, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic pin0_i, pin1_i, pin0_o, pin1_o, irq;
  logic [1:0] tirq, pin_q;
  logic [32:0] note_q[$];
  int exp_per[2][$];
  int exp_hi[2][$];
  int rise_t[2];
  int fall_t[2];
  int cyc_n, err_total, compares, gap, tgt;
  logic [15:0] r;
  logic [31:0] a;
  dtm_timer dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .first_timer_pin_i(pin0_i), .second_timer_pin_i(pin1_i),
    .first_timer_pin_o(pin0_o), .second_timer_pin_o(pin1_o),
    .tmr_irq_o(tirq), .irq_o(irq));
  dtm_pin_model pin (.core_clk_i(core_clk_i), .first_pin_o(pin0_i),
    .second_pin_o(pin1_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] tadr(int n, logic [7:0] off);
    return 8'(dtm_pkg::TMR_BASE + dtm_pkg::TMR_STRIDE * n) + off;
  endfunction
  // One classic cycle; the note goes to the watching process
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, input logic chk,
                      input logic [31:0] e, output logic [31:0] q);
    note_q.push_back({chk, e});
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat_w <= d;
    sel <= 4'hf;
    do @(posedge core_clk_i); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, ad, 32'h0000_0000, 1'b1, e, q);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, ad, d, 1'b0, 32'h0000_0000, q);
  endtask
  task automatic sync_tick(output logic [15:0] v);
    logic [31:0] p, q;
    xfer(1'b0, dtm_pkg::ADR_REFCNT, 32'h0000_0000, 1'b0, 32'h0, p);
    do xfer(1'b0, dtm_pkg::ADR_REFCNT, 32'h0, 1'b0, 32'h0, q);
    while (q === p);
    v = q[15:0];
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watch read data and pulse timing
  always @(posedge core_clk_i) begin
    logic [32:0] n;
    logic [1:0] po;
    cyc_n++;
    po = {pin1_o, pin0_o};
    if (ack === 1'b1 && note_q.size() > 0) begin
      n = note_q.pop_front();
      if (n[32]) check("rdata", dat_r, n[31:0]);
    end
    for (int i = 0; i < 2; i++) begin
      if (pin_q[i] === 1'b0 && po[i] === 1'b1) begin
        if (exp_per[i].size() > 0) begin
          check("period", cyc_n - rise_t[i], exp_per[i].pop_front());
          check("high", fall_t[i] - rise_t[i], exp_hi[i].pop_front());
        end
        rise_t[i] = cyc_n;
      end
      if (pin_q[i] === 1'b1 && po[i] === 1'b0)
        fall_t[i] = cyc_n;
    end
    pin_q <= po;
  end
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, adr, sel, dat_w, pin_q} = '0;
    {cyc_n, err_total, compares} = '0;
    nrst_i = 1'b0;
    void'($urandom(60));
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(dtm_pkg::ADR_REFCNT, 32'h0000_0000);
    rd(dtm_pkg::ADR_STATUS, 32'h0000_0000);
    rd(tadr(0, dtm_pkg::OFF_CTRL), 32'h0000_0000);
    wr(8'h7c, 32'hffff_ffff);
    rd(8'h7c, 32'h0000_0000);
    // Timebase: exactly 960 clocks between two takes
    xfer(1'b0, dtm_pkg::ADR_REFCNT, 32'h0, 1'b0, 32'h0, a);
    repeat (957) @(posedge core_clk_i);
    rd(dtm_pkg::ADR_REFCNT, 32'(a[15:0] + 16'h0005));
    a = $urandom;
    wr(tadr(1, dtm_pkg::OFF_RELOAD), a);
    rd(tadr(1, dtm_pkg::OFF_RELOAD), {16'h0000, a[15:0]});
    // Capture, masked then unmasked interrupt
    gap = 4 + $urandom % 8;
    wr(tadr(0, dtm_pkg::OFF_CTRL), {28'h0, dtm_pkg::DTM_RISE,
      dtm_pkg::DTM_CAPT});
    sync_tick(r);
    pin.pulses(0, 1, gap);
    repeat (8) @(posedge core_clk_i);
    rd(tadr(0, dtm_pkg::OFF_REF), {16'h0000, r});
    check("irq", irq, 1'b0);
    check("pin0", pin0_o, 1'b0);
    wr(dtm_pkg::ADR_MASK, 32'h0000_0008);
    @(posedge core_clk_i);
    check("tirq", tirq, 2'b01);
    rd(dtm_pkg::ADR_STATUS, 32'h0000_0008);
    @(posedge core_clk_i);
    check("irq", irq, 1'b0);
    pin.pulses(0, 1, gap);
    repeat (8) @(posedge core_clk_i);
    check("irq", irq, 1'b1);
    rd(dtm_pkg::ADR_STATUS, 32'h0000_0008);
    wr(tadr(0, dtm_pkg::OFF_CTRL), 32'h0000_0000);
    // Event count under every event kind
    for (int e = 0; e < 4; e++) begin
      tgt = (e == 2) ? 4 : 2 + $urandom % 3;
      wr(tadr(1, dtm_pkg::OFF_REF), tgt);
      wr(tadr(1, dtm_pkg::OFF_CTRL), {28'h0, 2'(e), dtm_pkg::DTM_EVENT});
      case (e)
        0, 1: begin
          pin.pulses(1, tgt - 1, gap);
          rd(dtm_pkg::ADR_STATUS, 32'h0000_0000);
          pin.pulses(1, 1, gap);
        end
        2: begin
          pin.pulses(1, 1, gap);
          pin.drive(1, 1'b1, gap);
          rd(dtm_pkg::ADR_STATUS, 32'h0000_0000);
          pin.drive(1, 1'b0, gap);
        end
        default: begin
          pin.drive(1, 1'b1, 192 * tgt + 96);
          pin.drive(1, 1'b0, gap);
        end
      endcase
      repeat (8) @(posedge core_clk_i);
      rd(dtm_pkg::ADR_STATUS, 32'h0000_0040);
      wr(tadr(1, dtm_pkg::OFF_CTRL), 32'h0000_0000);
    end
    // Both timers in match mode at once
    wr(tadr(0, dtm_pkg::OFF_RELOAD), 32'h0000_fff0);
    wr(tadr(0, dtm_pkg::OFF_REF), 32'h0000_0005);
    wr(tadr(1, dtm_pkg::OFF_RELOAD), 32'h0000_fff8);
    wr(tadr(1, dtm_pkg::OFF_REF), 32'h0000_0002);
    wr(tadr(0, dtm_pkg::OFF_CTRL), 32'h0000_0001);
    wr(tadr(1, dtm_pkg::OFF_CTRL), 32'h0000_0001);
    repeat (6500) @(posedge core_clk_i);
    repeat (2) begin
      exp_per[0].push_back(15 * 192);
      exp_hi[0].push_back(5 * 192);
      exp_per[1].push_back(7 * 192);
      exp_hi[1].push_back(2 * 192);
    end
    repeat (7000) @(posedge core_clk_i);
    check("pulses", exp_per[0].size() + exp_per[1].size(), 0);
    wr(tadr(0, dtm_pkg::OFF_CTRL), 32'h0000_0000);
    wr(tadr(1, dtm_pkg::OFF_CTRL), 32'h0000_0000);
    rd(dtm_pkg::ADR_STATUS, 32'h0000_0033);
    rd(dtm_pkg::ADR_STATUS, 32'h0000_0000);
    check("pins", {pin1_o, pin0_o}, 2'b00);
    wrap_up();
  end
endmodule // test_dtm_timer
`default_nettype wire
